// File: core/deser_cfg_pkg.sv
package deser_cfg_pkg;
   localparam int DATA_W = 24;
   localparam int CTRL_W = 3;
   // Strap positions on the shared data pins
   localparam int POS_COMPAT_LO = 23;
   localparam int POS_COMPAT_HI = 22;
   localparam int POS_SLEW_CLK = 21;
   localparam int POS_LOW_BAND = 20;
   localparam int POS_SLEW_DATA = 19;
   localparam int POS_SLEEP_SEL = 18;
   localparam int POS_EQ_LO = 12;
   localparam int POS_MAP_LO = 0;
   // Control filter and transition limits
   localparam int FILTER_MIN_CLKS = 3;
   localparam int WINDOW_CLKS = 130;
   localparam int MAX_TRANS_FIRST = 2;
   localparam int MAX_TRANS_THIRD = 1;
   // Power-up strap sampling time
   localparam int CLK_PERIOD_NS = 50;
   localparam int STRAP_TIME_NS = 1000;
   localparam int STRAP_CLKS = (STRAP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam logic [1:0] COMPAT_NOFILT = 2'h0;
   localparam logic [1:0] COMPAT_FILT = 2'h1;
   localparam logic [1:0] COMPAT_LEG_A = 2'h2;
   localparam logic [1:0] COMPAT_LEG_B = 2'h3;
   localparam logic [1:0] MAP_DEFAULT = 2'h0;
   typedef enum logic [1:0] {MODE_CURRENT, MODE_LEGACY_A, MODE_LEGACY_B} compat_mode_t;
   typedef enum {ST_TRISTATE, ST_SAMPLE, ST_RUN} pwr_state_t;
endpackage

// File: core/ctrl_shaper.sv
`timescale 1ns/1ps
module ctrl_shaper
#(
   parameter int MAX_TRANS = 2
)
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic in_i,
   input wire logic filter_en_i,
   output logic out_o
);
   import deser_cfg_pkg::*;

   logic [1:0] run_reg, run_next;
   logic stable_reg, stable_next;
   logic out_reg, out_next;
   logic [7:0] win_reg, win_next;
   logic [1:0] cnt_reg, cnt_next;
   logic cand;

   always_comb
   begin
      run_next = run_reg;
      stable_next = stable_reg;
      out_next = out_reg;
      win_next = win_reg;
      cnt_next = cnt_reg;
      // Pulse must persist FILTER_MIN_CLKS clocks when filter on
      if (in_i != stable_reg)
      begin
         run_next = 2'h0;
         stable_next = in_i;
      end
      else if (run_reg != 2'(FILTER_MIN_CLKS - 1))
      begin
         run_next = run_reg + 2'h1;
      end
      cand = filter_en_i ? ((run_reg == 2'(FILTER_MIN_CLKS - 1)) ? stable_reg : out_reg)
                         : in_i;
      if (win_reg != 8'h00)
      begin
         win_next = win_reg - 8'h01;
      end
      else
      begin
         cnt_next = 2'h0;
      end
      if (cand != out_reg && (win_reg == 8'h00 || cnt_reg < 2'(MAX_TRANS)))
      begin
         out_next = cand;
         if (win_reg == 8'h00)
         begin
            win_next = 8'(WINDOW_CLKS - 1);
            cnt_next = 2'h1;
         end
         else
         begin
            cnt_next = cnt_reg + 2'h1;
         end
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         run_reg <= 2'h0;
         stable_reg <= 1'b0;
         out_reg <= 1'b0;
         win_reg <= 8'h00;
         cnt_reg <= 2'h0;
      end
      else
      begin
         run_reg <= run_next;
         stable_reg <= stable_next;
         out_reg <= out_next;
         win_reg <= win_next;
         cnt_reg <= cnt_next;
      end
   end

   assign out_o = out_reg;

   a_trans_limit: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (win_reg != 8'h00) |-> (cnt_reg <= 2'(MAX_TRANS)))
      else $error("control transition limit exceeded");
endmodule

// File: core/deser_strap_config.sv
`timescale 1ns/1ps
module deser_strap_config
(
   input wire logic clk_i,
   input wire logic rst_n_i,
   input wire logic [deser_cfg_pkg::DATA_W-1:0] data_pins_i,
   input wire logic pll_locked_i,
   input wire logic [deser_cfg_pkg::DATA_W-1:0] rx_data_i,
   input wire logic [deser_cfg_pkg::CTRL_W-1:0] rx_ctrl_i,
   input wire logic rx_clk_phase_i,
   input wire logic self_test_i,
   input wire logic payload_error_i,
   input wire logic spread_enable_i,
   input wire logic reg_write_i,
   input wire logic [3:0] reg_eq_i,
   input wire logic reg_low_band_i,
   input wire logic reg_slew_clk_i,
   input wire logic reg_slew_data_i,
   input wire logic reg_sleep_sel_i,
   input wire logic [1:0] reg_map_i,
   input wire logic reg_hold_low_i,
   input wire logic hold_release_i,
   input wire logic hold_low_strap_i,
   output logic [deser_cfg_pkg::DATA_W-1:0] data_o,
   output logic [deser_cfg_pkg::DATA_W-1:0] data_oe_o,
   output logic control_out_first_o,
   output logic control_out_second_o,
   output logic control_out_third_o,
   output logic control_oe_o,
   output logic recovered_pixel_clock_o,
   output logic clock_oe_o,
   output logic lock_o,
   output logic pass_o,
   output logic pass_oe_o,
   output logic [3:0] rx_equalizer_setting_o,
   output logic spread_low_band_o,
   output logic clock_out_slew_select_o,
   output logic data_out_slew_select_o,
   output logic [1:0] map_select_o,
   output logic filter_enable_o,
   output logic [1:0] compat_mode_o
);
   import deser_cfg_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Synchronisers for pins
   logic [DATA_W-1:0] pins_s1_reg, pins_s2_reg;
   logic [1:0] lock_s_reg, err_s_reg, hls_s_reg;

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         pins_s1_reg <= '0;
         pins_s2_reg <= '0;
         lock_s_reg <= 2'h0;
         err_s_reg <= 2'h0;
         hls_s_reg <= 2'h0;
      end
      else
      begin
         pins_s1_reg <= data_pins_i;
         pins_s2_reg <= pins_s1_reg;
         lock_s_reg <= {lock_s_reg[0], pll_locked_i};
         err_s_reg <= {err_s_reg[0], payload_error_i};
         hls_s_reg <= {hls_s_reg[0], hold_low_strap_i};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Power-up sequencing and strap capture
   pwr_state_t state_reg, state_next;
   logic [7:0] tmr_reg, tmr_next;
   logic [DATA_W-1:0] strap_reg, strap_next;
   logic hold_strap_reg, hold_strap_next;

   always_comb
   begin
      state_next = state_reg;
      tmr_next = tmr_reg;
      strap_next = strap_reg;
      hold_strap_next = hold_strap_reg;
      case (state_reg)
         ST_TRISTATE:
         begin
            state_next = ST_SAMPLE;
            tmr_next = 8'h00;
         end
         ST_SAMPLE:
         begin
            tmr_next = tmr_reg + 8'h01;
            if (tmr_reg == 8'(STRAP_CLKS + 1))
            begin
               strap_next = pins_s2_reg;
               hold_strap_next = hls_s_reg[1];
               state_next = ST_RUN;
            end
         end
         ST_RUN:
         begin
            state_next = ST_RUN;
         end
         default:
         begin
            state_next = ST_TRISTATE;
         end
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         state_reg <= ST_TRISTATE;
         tmr_reg <= 8'h00;
         strap_reg <= '0;
         hold_strap_reg <= 1'b0;
      end
      else
      begin
         state_reg <= state_next;
         tmr_reg <= tmr_next;
         strap_reg <= strap_next;
         hold_strap_reg <= hold_strap_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Register overrides
   logic ovr_reg, ovr_next;
   logic [3:0] r_eq_reg, r_eq_next;
   logic [5:0] r_bits_reg, r_bits_next;
   logic released_reg, released_next;

   always_comb
   begin
      ovr_next = ovr_reg;
      r_eq_next = r_eq_reg;
      r_bits_next = r_bits_reg;
      released_next = released_reg | hold_release_i;
      if (reg_write_i)
      begin
         ovr_next = 1'b1;
         r_eq_next = reg_eq_i;
         r_bits_next = {reg_map_i, reg_low_band_i, reg_slew_clk_i, reg_slew_data_i,
                        reg_sleep_sel_i};
      end
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         ovr_reg <= 1'b0;
         r_eq_reg <= 4'h0;
         r_bits_reg <= {MAP_DEFAULT, 4'h0};
         released_reg <= 1'b0;
      end
      else
      begin
         ovr_reg <= ovr_next;
         r_eq_reg <= r_eq_next;
         r_bits_reg <= r_bits_next;
         released_reg <= released_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Effective configuration
   logic [1:0] compat;
   logic filt_en;
   logic hold_low;
   logic sleep_sel;

   always_comb
   begin
      compat = {strap_reg[POS_COMPAT_HI], strap_reg[POS_COMPAT_LO]};
      filt_en = (compat == COMPAT_FILT);
      hold_low = ovr_reg ? reg_hold_low_i : hold_strap_reg;
      sleep_sel = ovr_reg ? r_bits_reg[0] : strap_reg[POS_SLEEP_SEL];
   end

   ////////////////////////////////////////////////////////////////////////////
   // Control shaping
   logic [CTRL_W-1:0] ctrl_sh;

   ctrl_shaper #(.MAX_TRANS(MAX_TRANS_FIRST)) u_sh1 (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .in_i(rx_ctrl_i[0]), .filter_en_i(filt_en), .out_o(ctrl_sh[0]));
   ctrl_shaper #(.MAX_TRANS(MAX_TRANS_FIRST)) u_sh2 (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .in_i(rx_ctrl_i[1]), .filter_en_i(filt_en), .out_o(ctrl_sh[1]));
   ctrl_shaper #(.MAX_TRANS(MAX_TRANS_THIRD)) u_sh3 (.clk_i(clk_i), .rst_n_i(rst_n_i),
      .in_i(rx_ctrl_i[2]), .filter_en_i(1'b0), .out_o(ctrl_sh[2]));

   ////////////////////////////////////////////////////////////////////////////
   // Output gating
   logic [DATA_W-1:0] d_next, doe_next;
   logic [CTRL_W-1:0] c_next;
   logic ck_next, oe_next, lock_next, pass_next, run;

   always_comb
   begin
      run = (state_reg == ST_RUN);
      lock_next = run & lock_s_reg[1];
      oe_next = run;
      d_next = '0;
      c_next = '0;
      ck_next = 1'b0;
      doe_next = run ? '1 : '0;
      if (run && lock_s_reg[1] && !(hold_low && !released_reg))
      begin
         d_next = rx_data_i;
         c_next = ctrl_sh;
         ck_next = rx_clk_phase_i;
      end
      else if (run && !lock_s_reg[1] && sleep_sel && !hold_low)
      begin
         d_next = '1;
         c_next = '1;
         ck_next = 1'b1;
      end
      // Pass drops on error and stays low; high outside self-test
      pass_next = !self_test_i ? 1'b1 : (pass_o & ~err_s_reg[1]);
   end

   always_ff @(posedge clk_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         data_o <= '0;
         data_oe_o <= '0;
         control_out_first_o <= 1'b0;
         control_out_second_o <= 1'b0;
         control_out_third_o <= 1'b0;
         control_oe_o <= 1'b0;
         recovered_pixel_clock_o <= 1'b0;
         clock_oe_o <= 1'b0;
         lock_o <= 1'b0;
         pass_o <= 1'b1;
         pass_oe_o <= 1'b0;
         rx_equalizer_setting_o <= 4'h0;
         spread_low_band_o <= 1'b0;
         clock_out_slew_select_o <= 1'b0;
         data_out_slew_select_o <= 1'b0;
         map_select_o <= MAP_DEFAULT;
         filter_enable_o <= 1'b0;
         compat_mode_o <= 2'h0;
      end
      else
      begin
         data_o <= d_next;
         data_oe_o <= doe_next;
         control_out_first_o <= c_next[0];
         control_out_second_o <= c_next[1];
         control_out_third_o <= c_next[2];
         control_oe_o <= oe_next;
         recovered_pixel_clock_o <= ck_next;
         clock_oe_o <= oe_next;
         lock_o <= lock_next;
         pass_o <= pass_next;
         pass_oe_o <= oe_next;
         rx_equalizer_setting_o <= ovr_reg ? r_eq_reg : strap_reg[POS_EQ_LO +: 4];
         spread_low_band_o <= spread_enable_i &
            (ovr_reg ? r_bits_reg[3] : strap_reg[POS_LOW_BAND]);
         clock_out_slew_select_o <= ovr_reg ? r_bits_reg[2] : strap_reg[POS_SLEW_CLK];
         data_out_slew_select_o <= ovr_reg ? r_bits_reg[1] : strap_reg[POS_SLEW_DATA];
         map_select_o <= ovr_reg ? r_bits_reg[5:4] : strap_reg[POS_MAP_LO +: 2];
         filter_enable_o <= filt_en;
         compat_mode_o <= (compat == COMPAT_LEG_A) ? 2'(MODE_LEGACY_A) :
                          (compat == COMPAT_LEG_B) ? 2'(MODE_LEGACY_B) :
                          2'(MODE_CURRENT);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   a_tristate_early: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (state_reg != ST_RUN) |=> !data_oe_o[0] && !clock_oe_o)
      else $error("outputs driven before power-up done");
   a_lock_follows: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (run && lock_s_reg[1]) |=> lock_o)
      else $error("lock output missed");
   a_pass_sticky: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (self_test_i && err_s_reg[1]) ##1 self_test_i |=> !pass_o)
      else $error("pass stayed high after error");
   a_hold_low: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (hold_low && !released_reg) |=> (data_o == '0) && !recovered_pixel_clock_o)
      else $error("outputs not held low");
   a_strap_frozen: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (state_reg == ST_RUN) |=> $stable(strap_reg))
      else $error("strap changed after power-up");
   a_filter_code: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      filter_enable_o |-> $past(compat) == COMPAT_FILT)
      else $error("filter enable mismatch");
   a_low_band_gate: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      !$past(spread_enable_i) |-> !spread_low_band_o)
      else $error("low band active without spreading");
   a_unlock_sleep: assert property (@(posedge clk_i) disable iff (!rst_n_i)
      (run && !lock_s_reg[1] && !sleep_sel) |=> (data_o == '0))
      else $error("unlocked outputs not at sleep state");
endmodule

// File: verif/strap_board_model.sv
`timescale 1ns/1ps
module strap_board_model
   import deser_cfg_pkg::*;
(
   input wire logic [deser_cfg_pkg::DATA_W-1:0] strap_i,
   input wire logic hold_low_i,
   input wire logic [deser_cfg_pkg::DATA_W-1:0] data_i,
   input wire logic [deser_cfg_pkg::DATA_W-1:0] data_oe_i,
   input wire logic pass_i,
   input wire logic pass_oe_i,
   output logic [deser_cfg_pkg::DATA_W-1:0] pins_o,
   output logic hold_pin_o
);
   logic [DATA_W-1:0] level;
   // Hold-low board fits no other strap resistor
   assign level = hold_low_i ? '0 : strap_i;
   // Resistor level wherever the device leaves the pin undriven
   assign pins_o = (data_oe_i & data_i) | (~data_oe_i & level);
   assign hold_pin_o = pass_oe_i ? pass_i : hold_low_i;
endmodule

// File: verif/tb.sv
`timescale 1ns/1ps
module tb;
   import deser_cfg_pkg::*;
   typedef struct {int kind; logic [31:0] val;} note_t;
   note_t q[$];
   event chk;
   int n_mismatch = 0;
   int checks = 0;
   int n1 = 0, n3 = 0;
   logic clk = 0, rst_n = 0, locked = 0, rx_clk = 0, st_en = 0, perr = 0, ssc_en = 1;
   logic reg_wr = 0, reg_lb = 0, reg_sc = 0, reg_sd = 0, reg_ss = 0, reg_hold = 0;
   logic rel = 0, hold_strap = 0, c1_q = 0, c3_q = 0;
   logic hold_pin, c1, c2, c3, c_oe, pclk, clk_oe, lock, pass, pass_oe, lb, sc, sd, filt;
   logic [3:0] reg_eq = '0, eq;
   logic [1:0] reg_map = '0, map, compat;
   logic [2:0] rx_ctrl = '0;
   logic [DATA_W-1:0] strap = '0, rx_data = '0, pins, d_o, d_oe;
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      forever #25 clk = ~clk;
   end
   strap_board_model board (
      .strap_i(strap), .hold_low_i(hold_strap), .data_i(d_o), .data_oe_i(d_oe),
      .pass_i(pass), .pass_oe_i(pass_oe), .pins_o(pins), .hold_pin_o(hold_pin));
   deser_strap_config i_dut (
      .clk_i(clk), .rst_n_i(rst_n), .data_pins_i(pins), .pll_locked_i(locked),
      .rx_data_i(rx_data), .rx_ctrl_i(rx_ctrl), .rx_clk_phase_i(rx_clk),
      .self_test_i(st_en), .payload_error_i(perr), .spread_enable_i(ssc_en),
      .reg_write_i(reg_wr), .reg_eq_i(reg_eq), .reg_low_band_i(reg_lb),
      .reg_slew_clk_i(reg_sc), .reg_slew_data_i(reg_sd), .reg_sleep_sel_i(reg_ss),
      .reg_map_i(reg_map), .reg_hold_low_i(reg_hold), .hold_release_i(rel),
      .hold_low_strap_i(hold_pin), .data_o(d_o), .data_oe_o(d_oe),
      .control_out_first_o(c1), .control_out_second_o(c2), .control_out_third_o(c3),
      .control_oe_o(c_oe), .recovered_pixel_clock_o(pclk), .clock_oe_o(clk_oe),
      .lock_o(lock), .pass_o(pass), .pass_oe_o(pass_oe), .rx_equalizer_setting_o(eq),
      .spread_low_band_o(lb), .clock_out_slew_select_o(sc), .data_out_slew_select_o(sd),
      .map_select_o(map), .filter_enable_o(filt), .compat_mode_o(compat));
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [11:0] exp_cfg(input logic [DATA_W-1:0] s);
      logic [1:0] m;
      m = {s[POS_COMPAT_HI], s[POS_COMPAT_LO]};
      return {(m == COMPAT_LEG_A) ? 2'h1 : (m == COMPAT_LEG_B) ? 2'h2 : 2'h0,
         s[POS_EQ_LO+:4], s[POS_LOW_BAND], s[POS_SLEW_CLK], s[POS_SLEW_DATA],
         s[POS_MAP_LO+:2], m == COMPAT_FILT};
   endfunction
   task automatic report(input string what, input logic [31:0] got, input logic [31:0] e);
      checks++;
      if (got !== e)
      begin
         n_mismatch++;
         $display("[ERR] %0t %s got %h expected %h", $time, what, got, e);
      end
   endtask
   task automatic cmp_cfg(input logic [31:0] e);
      report("config", {20'h0, compat, eq, lb, sc, sd, map, filt}, e);
   endtask
   task automatic cmp_out(input logic [31:0] e);
      report("outputs", {c2, pclk, pass_oe, lock, clk_oe, c_oe, &d_oe, |d_oe, d_o}, e);
   endtask
   task automatic cmp_pass(input logic [31:0] e);
      report("pass", {31'h0, pass}, e);
   endtask
   task automatic cmp_cnt(input logic [31:0] e);
      report("control edges", {n1[15:0], n3[15:0]}, e);
   endtask
   task automatic cmp_data(input logic [31:0] e);
      report("data", {8'h0, d_o}, e);
   endtask
   task automatic summarize();
      $display("checks %0d mismatches %0d", checks, n_mismatch);
      if (n_mismatch == 0 && checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   task automatic tick(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic note(input int k, input logic [31:0] v);
      q.push_back('{k, v});
      -> chk;
   endtask
   task automatic power_up(input logic [DATA_W-1:0] s, input logic h);
      rst_n = 0;
      locked = 0;
      st_en = 0;
      strap = s;
      hold_strap = h;
      reg_hold = h;
      tick(3);
      note(1, 0);
      rst_n = 1;
      for (int i = 0; i < 60 && clk_oe !== 1'b1; i++)
         tick(1);
      tick(2);
   endtask
   task automatic lock_up(input logic [DATA_W-1:0] d);
      rx_data = d;
      rx_clk = d[0];
      locked = 1;
      for (int i = 0; i < 10 && lock !== 1'b1; i++)
         tick(1);
      tick(2);
   endtask
   task automatic pulse(input int b, input int len);
      rx_ctrl[b] = 1'b1;
      tick(len);
      rx_ctrl[b] = 1'b0;
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   // Monitor side: edge counters and the checker of queued notes
   always @(posedge clk)
   begin
      if (c1 !== c1_q)
         n1++;
      if (c3 !== c3_q)
         n3++;
      c1_q = c1;
      c3_q = c3;
   end
   initial
   begin
      note_t n;
      forever
      begin
         @chk;
         while (q.size() > 0)
         begin
            n = q.pop_front();
            case (n.kind)
               0: cmp_cfg(n.val);
               1: cmp_out(n.val);
               2: cmp_pass(n.val);
               3: cmp_cnt(n.val);
               default: cmp_data(n.val);
            endcase
         end
      end
   end
   initial
   begin
      repeat (3000) @(posedge clk);
      $display("[ERR] %0t watchdog timeout", $time);
      n_mismatch++;
      summarize();
   end
   ////////////////////////////////////////////////////////////////////////////////
   initial
   begin
      logic [DATA_W-1:0] s;
      logic [11:0] e;
      logic [8:0] r;
      void'($urandom(96));
      for (int k = 0; k < 4; k++)
      begin
         s = DATA_W'($urandom());
         s[POS_COMPAT_HI] = k[1];
         s[POS_COMPAT_LO] = k[0];
         s[POS_SLEEP_SEL] = k[1];
         power_up(s, 1'b0);
         note(0, exp_cfg(s));
         note(1, {{2{s[POS_SLEEP_SEL]}}, 6'h2F, {DATA_W{s[POS_SLEEP_SEL]}}});
         lock_up(DATA_W'($urandom()));
         note(1, {1'b0, rx_clk, 6'h3F, rx_data});
         if (k < 2)
         begin
            n1 = 0;
            n3 = 0;
            pulse(0, 2);
            tick(6);
            pulse(0, 2);
            pulse(2, 4);
            tick(10);
            note(3, {16'(k == 0 ? 2 : 0), 16'h1});
         end
         strap = ~s;
         rx_data = ~rx_data;
         tick(5);
         note(0, exp_cfg(s));
      end
      // Register override keeps the strapped compat code
      r = 9'($urandom());
      {reg_eq, reg_lb, reg_sc, reg_sd, reg_map} = r;
      reg_ss = r[0];
      reg_wr = 1;
      tick(1);
      reg_wr = 0;
      tick(3);
      e = exp_cfg(s);
      e[9:1] = r;
      note(0, e);
      // Power-down in mid-run drops the override
      s = DATA_W'($urandom());
      ssc_en = 0;
      power_up(s, 1'b0);
      e = exp_cfg(s);
      e[5] = 1'b0;
      note(0, e);
      lock_up(DATA_W'($urandom()));
      st_en = 1;
      tick(4);
      note(2, 1);
      perr = 1;
      tick(1);
      perr = 0;
      tick(4);
      note(2, 0);
      // Hold-low strap, then software release
      power_up(DATA_W'($urandom()), 1'b1);
      note(0, exp_cfg('0));
      lock_up(DATA_W'($urandom()) | 24'h1);
      note(4, 0);
      rel = 1;
      tick(1);
      rel = 0;
      tick(3);
      note(4, {8'h0, rx_data});
      tick(1);
      summarize();
   end
endmodule
